// *** hdl/e1_tx_sa_cfg.svh ***
// offsets, field positions and reset values of the transmit overhead bit bank
// Functional notes
// - spare4 bit n feeds Sa4 of frame 2n+1
// - spare5 bit n feeds Sa5 of frame 2n+1
// - spare6 bit n feeds Sa6 of frame 2n+1
// - spare7 bit n feeds Sa7 of frame 2n+1
// - spare8 bit n feeds Sa8 of frame 2n+1
// - control bit 0 enables Sa8 insertion
// - control bit 1 enables Sa7 insertion
// - control bit 2 enables Sa6 insertion
// - control bit 3 enables Sa5 insertion
// - control bit 4 enables Sa4 insertion
// - control bit 5 enables remote alarm insertion
// - control bit 6 enables nonalign Si insertion
// - control bit 7 enables align Si insertion
// - align Si bit n feeds frame 2n
// - nonalign Si bit n feeds frame 2n+1
// - alarm bit n feeds frame 2n+1
`ifndef E1_TX_SA_CFG_SVH
`define E1_TX_SA_CFG_SVH

`define ADDR_INTL_ALIGN    8'hd2
`define ADDR_INTL_NONALIGN 8'hd3
`define ADDR_ALARM_SOURCE  8'hd4
`define ADDR_SPARE4        8'hd5
`define ADDR_SPARE5        8'hd6
`define ADDR_SPARE6        8'hd7
`define ADDR_SPARE7        8'hd8
`define ADDR_SPARE8        8'hd9
`define ADDR_OH_CTRL       8'hda

`define REG_COUNT          9
`define IDX_INTL_ALIGN     0
`define IDX_INTL_NONALIGN  1
`define IDX_ALARM_SOURCE   2
`define IDX_SPARE4         3
`define IDX_SPARE5         4
`define IDX_SPARE6         5
`define IDX_SPARE7         6
`define IDX_SPARE8         7
`define IDX_OH_CTRL        8

`define SPARE_GROUPS       5
`define CTRL_SA8_BIT       0
`define CTRL_SA7_BIT       1
`define CTRL_SA6_BIT       2
`define CTRL_SA5_BIT       3
`define CTRL_SA4_BIT       4
`define CTRL_ALARM_BIT     5
`define CTRL_INTL_NONALIGN_INSERT_EN_BIT     6
`define CTRL_INTL_ALIGN_INSERT_EN_BIT      7

`define TX_REG_RESET       8'h00
`define RDATA_IDLE         8'h00

`endif

// *** hdl/e1_tx_sa_pkg.sv ***
// types shared by the transmit overhead bit bank
package e1_tx_sa_pkg;
   typedef logic [7:0] byte_type;
   typedef logic [8:0] reg_sel_type;
   typedef byte_type [8:0] reg_bank_type;
   typedef byte_type [4:0] spare_bank_type;

   typedef struct packed {
      reg_bank_type bank;
      byte_type     rd_data;
      logic         out_valid;
      logic         out_si;
      logic         out_alarm;
      logic [4:0]   out_sa;
   } bank_state_type;
endpackage

// *** hdl/sel_bus.sv ***
// signals between the register bank and the overhead bit selector
`timescale 1ns/100ps
interface sel_bus;
   logic [3:0]                  frame_index;
   logic                        src_si;
   logic                        src_alarm;
   logic [4:0]                  src_sa;
   e1_tx_sa_pkg::byte_type      ctrl;
   e1_tx_sa_pkg::byte_type      intl_align;
   e1_tx_sa_pkg::byte_type      intl_nonalign;
   e1_tx_sa_pkg::byte_type      alarm_src;
   e1_tx_sa_pkg::spare_bank_type spare;
   logic                        sel_si;
   logic                        sel_alarm;
   logic [4:0]                  sel_sa;

   modport select_side (
      input  frame_index, src_si, src_alarm, src_sa, ctrl,
      input  intl_align, intl_nonalign, alarm_src, spare,
      output sel_si, sel_alarm, sel_sa
   );
   modport bank_side (
      output frame_index, src_si, src_alarm, src_sa, ctrl,
      output intl_align, intl_nonalign, alarm_src, spare,
      input  sel_si, sel_alarm, sel_sa
   );
endinterface

// *** hdl/overhead_select.sv ***
// per-frame choice between register bits and the framer's own overhead bits
`timescale 1ns/100ps
`include "e1_tx_sa_cfg.svh"
module overhead_select (
   sel_bus.select_side bus
);
   // bit n of a bank serves frame 2n or 2n+1, so the frame index drops its low bit
   function automatic logic frame_bit(input e1_tx_sa_pkg::byte_type bits,
                                      input logic [3:0] idx);
      return bits[idx[3:1]];
   endfunction

   logic odd_frame;
   assign odd_frame = bus.frame_index[0];

   // Sa and alarm bits live only in nonalign (odd) frames; even frames pass them through
   genvar g;
   generate
      for (g = 0; g < `SPARE_GROUPS; g = g + 1) begin : g_spare
         logic ins_en;
         logic reg_bit;
         // group 0 is Sa4 on control bit 4, group 4 is Sa8 on control bit 0
         assign ins_en = odd_frame && bus.ctrl[`CTRL_SA4_BIT - g];
         assign reg_bit = frame_bit(bus.spare[g], bus.frame_index);
         assign bus.sel_sa[g] = ins_en ? reg_bit : bus.src_sa[g];
      end
   endgenerate

   assign bus.sel_alarm = (odd_frame && bus.ctrl[`CTRL_ALARM_BIT]) ?
                          frame_bit(bus.alarm_src, bus.frame_index) :
                          bus.src_alarm;

   always_comb begin
      if (odd_frame) begin
         bus.sel_si = bus.ctrl[`CTRL_INTL_NONALIGN_INSERT_EN_BIT] ?
                      frame_bit(bus.intl_nonalign, bus.frame_index) :
                      bus.src_si;
      end else begin
         bus.sel_si = bus.ctrl[`CTRL_INTL_ALIGN_INSERT_EN_BIT] ?
                      frame_bit(bus.intl_align, bus.frame_index) :
                      bus.src_si;
      end
   end
endmodule // overhead_select

// *** hdl/e1_tx_sa_bit_insertion.sv ***
// host register bank and registered overhead bit insertion for the e1 transmitter
`timescale 1ns/100ps
`include "e1_tx_sa_cfg.svh"
module e1_tx_sa_bit_insertion (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   input  wire logic [7:0] host_addr,
   input  wire logic [7:0] host_wdata,
   input  wire logic       host_wr,
   input  wire logic       host_rd,
   output logic      [7:0] host_rdata,
   input  wire logic       frame_strobe,
   input  wire logic [3:0] frame_index,
   input  wire logic       src_si,
   input  wire logic       src_alarm,
   input  wire logic [4:0] src_sa,
   output logic            ins_valid,
   output logic            ins_si,
   output logic            ins_alarm,
   output logic      [4:0] ins_sa
);
   e1_tx_sa_pkg::bank_state_type s;
   e1_tx_sa_pkg::bank_state_type next_s;
   e1_tx_sa_pkg::reg_sel_type    wr_sel;
   e1_tx_sa_pkg::reg_sel_type    rd_sel;

   sel_bus bus ();

   // one decode serves both the write and the read path
   function automatic e1_tx_sa_pkg::reg_sel_type reg_select(input logic [7:0] addr);
      e1_tx_sa_pkg::reg_sel_type sel;
      sel = '0;
      for (int i = 0; i < `REG_COUNT; i++) begin
         sel[i] = (addr == (`ADDR_INTL_ALIGN + 8'(i)));
      end
      return sel;
   endfunction

   assign wr_sel = reg_select(host_addr);
   assign rd_sel = reg_select(host_addr);

   // register bank facing the selector
   assign bus.frame_index   = frame_index;
   assign bus.src_si        = src_si;
   assign bus.src_alarm     = src_alarm;
   assign bus.src_sa        = src_sa;
   assign bus.ctrl          = s.bank[`IDX_OH_CTRL];
   assign bus.intl_align    = s.bank[`IDX_INTL_ALIGN];
   assign bus.intl_nonalign = s.bank[`IDX_INTL_NONALIGN];
   assign bus.alarm_src     = s.bank[`IDX_ALARM_SOURCE];

   genvar g;
   generate
      for (g = 0; g < `SPARE_GROUPS; g = g + 1) begin : g_bank
         assign bus.spare[g] = s.bank[`IDX_SPARE4 + g];
      end
   endgenerate

   overhead_select u_select (
      .bus (bus.select_side)
   );

   always_comb begin
      next_s = s;
      if (clk_en) begin
         for (int i = 0; i < `REG_COUNT; i++) begin
            if (host_wr && wr_sel[i]) begin
               next_s.bank[i] = host_wdata;
            end
         end
         // unmapped addresses read as zero
         if (host_rd) begin
            next_s.rd_data = `RDATA_IDLE;
            for (int i = 0; i < `REG_COUNT; i++) begin
               if (rd_sel[i]) begin
                  next_s.rd_data = s.bank[i];
               end
            end
         end
         // a write in the same cycle as a frame takes effect from the next frame
         next_s.out_valid = frame_strobe;
         if (frame_strobe) begin
            next_s.out_si    = bus.sel_si;
            next_s.out_alarm = bus.sel_alarm;
            next_s.out_sa    = bus.sel_sa;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < `REG_COUNT; i++) begin
            s.bank[i] <= `TX_REG_RESET;
         end
         s.rd_data   <= `RDATA_IDLE;
         s.out_valid <= 1'b0;
         s.out_si    <= 1'b0;
         s.out_alarm <= 1'b0;
         s.out_sa    <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign host_rdata = s.rd_data;
   assign ins_valid  = s.out_valid;
   assign ins_si     = s.out_si;
   assign ins_alarm  = s.out_alarm;
   assign ins_sa     = s.out_sa;

   // helper copies of the frame request, read only by the checks below
   logic [2:0] chk_pos;
   logic       chk_odd;
   always_ff @(posedge sys_clk) begin
      chk_pos <= frame_index[3:1];
      chk_odd <= frame_index[0];
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence s_frame(bit odd);
      clk_en && frame_strobe && !host_wr && (frame_index[0] == odd);
   endsequence

   property p_sa4_insert;
      s_frame(1'b1) ##0 s.bank[`IDX_OH_CTRL][`CTRL_SA4_BIT]
         |=> ins_valid && ins_sa[0] == s.bank[`IDX_SPARE4][chk_pos];
   endproperty
   a_sa4_insert: assert property (p_sa4_insert) else $error("sa4 bit not from register");

   property p_sa5_insert;
      s_frame(1'b1) ##0 s.bank[`IDX_OH_CTRL][`CTRL_SA5_BIT]
         |=> ins_sa[1] == s.bank[`IDX_SPARE5][chk_pos];
   endproperty
   a_sa5_insert: assert property (p_sa5_insert) else $error("sa5 bit not from register");

   property p_sa6_insert;
      s_frame(1'b1) ##0 s.bank[`IDX_OH_CTRL][`CTRL_SA6_BIT]
         |=> ins_sa[2] == s.bank[`IDX_SPARE6][chk_pos];
   endproperty
   a_sa6_insert: assert property (p_sa6_insert) else $error("sa6 bit not from register");

   property p_sa7_insert;
      s_frame(1'b1) ##0 s.bank[`IDX_OH_CTRL][`CTRL_SA7_BIT]
         |=> ins_sa[3] == s.bank[`IDX_SPARE7][chk_pos];
   endproperty
   a_sa7_insert: assert property (p_sa7_insert) else $error("sa7 bit not from register");

   property p_sa8_insert;
      s_frame(1'b1) ##0 s.bank[`IDX_OH_CTRL][`CTRL_SA8_BIT]
         |=> ins_sa[4] == s.bank[`IDX_SPARE8][chk_pos];
   endproperty
   a_sa8_insert: assert property (p_sa8_insert) else $error("sa8 bit not from register");

   property p_alarm_insert;
      s_frame(1'b1) ##0 s.bank[`IDX_OH_CTRL][`CTRL_ALARM_BIT]
         |=> ins_alarm == s.bank[`IDX_ALARM_SOURCE][chk_pos];
   endproperty
   a_alarm_insert: assert property (p_alarm_insert) else $error("alarm bit not from register");

   property p_si_nonalign;
      s_frame(1'b1) ##0 s.bank[`IDX_OH_CTRL][`CTRL_INTL_NONALIGN_INSERT_EN_BIT]
         |=> ins_si == s.bank[`IDX_INTL_NONALIGN][chk_pos];
   endproperty
   a_si_nonalign: assert property (p_si_nonalign) else $error("nonalign si not from register");

   property p_si_align;
      s_frame(1'b0) ##0 s.bank[`IDX_OH_CTRL][`CTRL_INTL_ALIGN_INSERT_EN_BIT]
         |=> ins_si == s.bank[`IDX_INTL_ALIGN][chk_pos] && !chk_odd;
   endproperty
   a_si_align: assert property (p_si_align) else $error("align si not from register");

   property p_pass_through;
      clk_en && frame_strobe && s.bank[`IDX_OH_CTRL] == `TX_REG_RESET
         |=> ins_si == $past(src_si) && ins_alarm == $past(src_alarm)
             && ins_sa == $past(src_sa);
   endproperty
   a_pass_through: assert property (p_pass_through) else $error("source bits not passed");

   property p_even_sa_pass;
      s_frame(1'b0) |=> ins_sa == $past(src_sa) && ins_alarm == $past(src_alarm);
   endproperty
   a_even_sa_pass: assert property (p_even_sa_pass) else $error("even frame sa altered");

   property p_readback;
      clk_en && host_wr && host_addr == `ADDR_OH_CTRL
         ##1 clk_en && host_rd && host_addr == `ADDR_OH_CTRL && !host_wr
         |=> host_rdata == $past(host_wdata, 2);
   endproperty
   a_readback: assert property (p_readback) else $error("control readback wrong");

   property p_freeze;
      !clk_en |=> $stable(s);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");

   // a disabled field must hand the framer's own bit through untouched
   property p_sa4_pass;
      s_frame(1'b1) ##0 !s.bank[`IDX_OH_CTRL][`CTRL_SA4_BIT]
         |=> ins_sa[0] == $past(src_sa[0]);
   endproperty
   a_sa4_pass: assert property (p_sa4_pass) else $error("sa4 bit not passed");

   property p_sa5_pass;
      s_frame(1'b1) ##0 !s.bank[`IDX_OH_CTRL][`CTRL_SA5_BIT]
         |=> ins_sa[1] == $past(src_sa[1]);
   endproperty
   a_sa5_pass: assert property (p_sa5_pass) else $error("sa5 bit not passed");

   property p_sa6_pass;
      s_frame(1'b1) ##0 !s.bank[`IDX_OH_CTRL][`CTRL_SA6_BIT]
         |=> ins_sa[2] == $past(src_sa[2]);
   endproperty
   a_sa6_pass: assert property (p_sa6_pass) else $error("sa6 bit not passed");

   property p_sa7_pass;
      s_frame(1'b1) ##0 !s.bank[`IDX_OH_CTRL][`CTRL_SA7_BIT]
         |=> ins_sa[3] == $past(src_sa[3]);
   endproperty
   a_sa7_pass: assert property (p_sa7_pass) else $error("sa7 bit not passed");

   property p_sa8_pass;
      s_frame(1'b1) ##0 !s.bank[`IDX_OH_CTRL][`CTRL_SA8_BIT]
         |=> ins_sa[4] == $past(src_sa[4]);
   endproperty
   a_sa8_pass: assert property (p_sa8_pass) else $error("sa8 bit not passed");

   property p_alarm_pass;
      s_frame(1'b1) ##0 !s.bank[`IDX_OH_CTRL][`CTRL_ALARM_BIT]
         |=> ins_alarm == $past(src_alarm);
   endproperty
   a_alarm_pass: assert property (p_alarm_pass) else $error("alarm bit not passed");

   property p_si_nonalign_pass;
      s_frame(1'b1) ##0 !s.bank[`IDX_OH_CTRL][`CTRL_INTL_NONALIGN_INSERT_EN_BIT]
         |=> ins_si == $past(src_si);
   endproperty
   a_si_nonalign_pass: assert property (p_si_nonalign_pass) else $error("odd si not passed");

   property p_si_align_pass;
      s_frame(1'b0) ##0 !s.bank[`IDX_OH_CTRL][`CTRL_INTL_ALIGN_INSERT_EN_BIT]
         |=> ins_si == $past(src_si);
   endproperty
   a_si_align_pass: assert property (p_si_align_pass) else $error("even si not passed");

   property p_valid_follows;
      clk_en |=> ins_valid == $past(frame_strobe);
   endproperty
   a_valid_follows: assert property (p_valid_follows) else $error("valid not one cycle");

   // the framer may sample late, so chosen bits stand until the next frame
   property p_out_hold;
      clk_en && !frame_strobe
         |=> $stable(ins_si) && $stable(ins_alarm) && $stable(ins_sa);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("chosen bits moved");

   property p_rdata_hold;
      !(clk_en && host_rd) |=> $stable(host_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

   property p_unmapped_zero;
      clk_en && host_rd && rd_sel == '0 |=> host_rdata == `RDATA_IDLE;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("hole did not read zero");

   property p_reset_clears;
      disable iff (1'b0)
      reset |=> !ins_valid && host_rdata == `RDATA_IDLE && ins_sa == '0
                && s.bank[`IDX_OH_CTRL] == `TX_REG_RESET;
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset left state");

   property p_spare4_write;
      clk_en && host_wr && host_addr == `ADDR_SPARE4
         |=> s.bank[`IDX_SPARE4] == $past(host_wdata);
   endproperty
   a_spare4_write: assert property (p_spare4_write) else $error("sa4 write lost");

   property p_spare8_write;
      clk_en && host_wr && host_addr == `ADDR_SPARE8
         |=> s.bank[`IDX_SPARE8] == $past(host_wdata);
   endproperty
   a_spare8_write: assert property (p_spare8_write) else $error("sa8 write lost");

   property p_ctrl_write;
      clk_en && host_wr && host_addr == `ADDR_OH_CTRL
         |=> s.bank[`IDX_OH_CTRL] == $past(host_wdata);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   property p_align_write;
      clk_en && host_wr && host_addr == `ADDR_INTL_ALIGN
         |=> s.bank[`IDX_INTL_ALIGN] == $past(host_wdata);
   endproperty
   a_align_write: assert property (p_align_write) else $error("align si write lost");

   c_all_insert: cover property (clk_en && frame_strobe && frame_index[0]
                                 && s.bank[`IDX_OH_CTRL] == 8'hff);
   c_even_align: cover property (s_frame(1'b0) ##0 s.bank[`IDX_OH_CTRL][`CTRL_INTL_ALIGN_INSERT_EN_BIT]);
   c_last_frame: cover property (clk_en && frame_strobe && frame_index == 4'hf
                                 && s.bank[`IDX_OH_CTRL][`CTRL_SA4_BIT]);
   c_write_hit:  cover property (clk_en && host_wr && frame_strobe);
   c_frozen:     cover property (!clk_en && frame_strobe);
endmodule // e1_tx_sa_bit_insertion

// *** test/framer_model.sv ***
// framer model that hands the block one frame's normal overhead bits
`timescale 1ns/100ps
module framer_model (
   input  wire logic       sys_clk,
   output logic            frame_strobe,
   output logic      [3:0] frame_index,
   output logic            src_si,
   output logic            src_alarm,
   output logic      [4:0] src_sa
);
   initial begin
      frame_strobe = 1'b0;
      frame_index  = 4'h0;
      src_si       = 1'b0;
      src_alarm    = 1'b0;
      src_sa       = 5'h00;
   end
   // one-cycle strobe with index and source bits held beside it
   task automatic send(input logic [3:0] idx, input logic si, input logic al,
                       input logic [4:0] sa);
      @(posedge sys_clk);
      #1;
      frame_strobe = 1'b1;
      frame_index  = idx;
      src_si       = si;
      src_alarm    = al;
      src_sa       = sa;
      @(posedge sys_clk);
      #1;
      frame_strobe = 1'b0;
      // stale bits inverted so a late sample cannot match by luck
      src_si       = ~src_si;
      src_alarm    = ~src_alarm;
      src_sa       = ~src_sa;
   endtask
endmodule // framer_model

// *** test/e1_tx_sa_bit_insertion_tb.sv ***
// self-checking bench for the transmit overhead bit bank
`timescale 1ns/100ps
`include "e1_tx_sa_cfg.svh"
module e1_tx_sa_bit_insertion_tb;
   logic                   sys_clk;
   logic                   reset;
   logic                   clk_en;
   logic             [7:0] host_addr;
   logic             [7:0] host_wdata;
   logic                   host_wr;
   logic                   host_rd;
   logic             [7:0] host_rdata;
   logic                   frame_strobe;
   logic             [3:0] frame_index;
   logic                   src_si;
   logic                   src_alarm;
   logic             [4:0] src_sa;
   logic                   ins_valid;
   logic                   ins_si;
   logic                   ins_alarm;
   logic             [4:0] ins_sa;
   int                     errors;
   int                     tests_run;
   e1_tx_sa_pkg::byte_type regs [9];

   e1_tx_sa_bit_insertion e1_tx_sa_bit_insertion_inst (.sys_clk, .reset, .clk_en,
      .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata, .frame_strobe,
      .frame_index, .src_si, .src_alarm, .src_sa, .ins_valid, .ins_si, .ins_alarm,
      .ins_sa);
   framer_model framer_model_inst (.sys_clk, .frame_strobe, .frame_index, .src_si,
      .src_alarm, .src_sa);

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic give_verdict;
      $display("compares %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      host_addr  = a;
      host_wdata = d;
      host_wr    = 1'b1;
      @(posedge sys_clk);
      #1;
      host_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      #1;
      host_addr = a;
      host_rd   = 1'b1;
      @(posedge sys_clk);
      #1;
      host_rd = 1'b0;
      chk(host_rdata, exp, "read");
   endtask

   // expected {valid, si, alarm, sa}; sa bit k is enabled by control bit 4-k
   function automatic logic [7:0] exp_oh(input logic [3:0] i, input logic [7:0] c,
                                        input logic si, input logic al, input logic [4:0] sa);
      logic [7:0] r;
      r = {1'b1, si, al, sa};
      if (!i[0] && c[7]) r[6] = regs[0][i[3:1]];
      if (i[0]) begin
         if (c[6]) r[6] = regs[1][i[3:1]];
         if (c[5]) r[5] = regs[2][i[3:1]];
         for (int k = 0; k < 5; k++) begin
            if (c[4 - k]) r[k] = regs[3 + k][i[3:1]];
         end
      end
      return r;
   endfunction

   task automatic t_reset_vals;
      for (int i = 0; i < 9; i++) begin
         rd(`ADDR_INTL_ALIGN + 8'(i), 8'h00);
      end
      rd(8'hdb, 8'h00);
      chk({ins_valid, ins_si, ins_alarm, ins_sa}, 8'h00, "idle outputs");
      $display("test reset values done");
   endtask

   task automatic t_regs;
      regs = '{8'h5a, 8'ha5, 8'h3c, 8'h96, 8'h69, 8'hc3, 8'h0f, 8'hf0, 8'h81};
      for (int i = 0; i < 9; i++) begin
         wr(`ADDR_INTL_ALIGN + 8'(i), regs[i]);
      end
      // unmapped writes must not alias onto a neighbour
      wr(8'hd1, 8'hff);
      wr(8'hdb, 8'hff);
      for (int i = 0; i < 9; i++) begin
         rd(`ADDR_INTL_ALIGN + 8'(i), regs[i]);
      end
      rd(8'hd1, 8'h00);
      $display("test register access done");
   endtask

   // source bits are the inverse of the register bits, so any wrong choice shows
   task automatic t_frames(input logic [7:0] c);
      logic       si;
      logic       al;
      logic [4:0] sa;
      wr(`ADDR_OH_CTRL, c);
      regs[8] = c;
      for (int i = 0; i < 16; i++) begin
         si = ~regs[i[0]][i[3:1]];
         al = ~regs[2][i[3:1]];
         for (int k = 0; k < 5; k++) begin
            sa[k] = ~regs[3 + k][i[3:1]];
         end
         framer_model_inst.send(4'(i), si, al, sa);
         chk({ins_valid, ins_si, ins_alarm, ins_sa}, exp_oh(4'(i), c, si, al, sa), "frame");
         @(posedge sys_clk);
         #1;
         chk({7'h00, ins_valid}, 8'h00, "valid pulse");
      end
      $display("test frames with control %h done", c);
   endtask

   task automatic t_mid_reset;
      @(posedge sys_clk);
      #1;
      reset = 1'b1;
      @(posedge sys_clk);
      #1;
      reset = 1'b0;
      chk({ins_valid, ins_si, ins_alarm, ins_sa}, 8'h00, "outputs after reset");
      rd(`ADDR_OH_CTRL, 8'h00);
      rd(`ADDR_SPARE4, 8'h00);
      $display("test second reset done");
   endtask

   // clk_en low ignores a write and a frame; then same-cycle and back-to-back access
   task automatic t_freeze;
      @(posedge sys_clk);
      #1;
      clk_en     = 1'b0;
      host_addr  = `ADDR_SPARE4;
      host_wdata = 8'h5a;
      host_wr    = 1'b1;
      framer_model_inst.send(4'h1, 1'b1, 1'b1, 5'h1f);
      host_wr = 1'b0;
      clk_en  = 1'b1;
      chk({ins_valid, ins_si, ins_alarm, ins_sa}, 8'h00, "frozen frame");
      rd(`ADDR_SPARE4, 8'h00);
      @(posedge sys_clk);
      #1;
      host_addr  = `ADDR_OH_CTRL;
      host_wdata = 8'h3c;
      host_wr    = 1'b1;
      host_rd    = 1'b1;
      @(posedge sys_clk);
      #1;
      host_wr = 1'b0;
      chk(host_rdata, 8'h00, "read beside write");
      @(posedge sys_clk);
      #1;
      host_rd = 1'b0;
      chk(host_rdata, 8'h3c, "back-to-back read");
      $display("test clock enable done");
   endtask

   initial begin
      errors     = 0;
      tests_run  = 0;
      reset      = 1'b1;
      clk_en     = 1'b1;
      host_addr  = 8'h00;
      host_wdata = 8'h00;
      host_wr    = 1'b0;
      host_rd    = 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      t_reset_vals;
      t_regs;
      t_frames(8'h00);
      for (int b = 0; b < 8; b++) begin
         t_frames(8'h01 << b);
      end
      t_frames(8'hff);
      t_mid_reset;
      t_freeze;
      give_verdict;
   end

   // about 600 cycles are needed; the limit leaves ample margin
   initial begin
      #200000;
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict;
   end
endmodule // e1_tx_sa_bit_insertion_tb
